// File: hw/dccs_consts.svh
// Purpose: offsets, field positions, reset values and timing figures of the clock control
// Assumes: byte addresses on an 8-bit APB address, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef DCCS_CONSTS_SVH
`define DCCS_CONSTS_SVH

`define DCCS_ADDR_W        8
`define DCCS_OFS_CTRL      8'h00
`define DCCS_OFS_DIV       8'h04
`define DCCS_OFS_SRATE     8'h08
`define DCCS_OFS_RRATE     8'h0c
`define DCCS_OFS_XOFS      8'h10
`define DCCS_OFS_XSKEW     8'h14
`define DCCS_OFS_COMMIT    8'h18
`define DCCS_OFS_STATUS    8'h1c

`define DCCS_CTRL_COMMON   0
`define DCCS_CTRL_CH1_SRC  1
`define DCCS_CTRL_CH2_SRC  2
`define DCCS_CTRL_REF_SRC  3
`define DCCS_DIV_CH1_LSB   0
`define DCCS_DIV_CH2_LSB   4
`define DCCS_COMMIT_BIT    0

`define DCCS_ST_SRATE_ACT  4
`define DCCS_ST_ALIGN_ACT  5
`define DCCS_ST_DIV1_LSB   8
`define DCCS_ST_DIV2_LSB   12

`define DCCS_RST_WORD      32'h00000000
`define DCCS_DIV_EXP_MAX   4'h8

`define DCCS_SKEW_STEP_PS  10
`define DCCS_SKEW_MAX_PS   3000
`define DCCS_SKEW_LIMIT    (`DCCS_SKEW_MAX_PS / `DCCS_SKEW_STEP_PS)
`define DCCS_INT_REF_MHZ   100
`define DCCS_INT_REF_KHZ   (`DCCS_INT_REF_MHZ * 1000)

`endif

// File: hw/dccs_pkg.sv
// Purpose: types shared by the clock control files
// Assumes: rates held in kHz, offset in sample periods, skew in 10 ps steps
// Notes:   numbers live in dccs_consts.svh
package dccs_pkg;

    typedef struct packed {
        logic                   common;
        logic [1:0]             chExternal;
        logic                   refExternal;
        logic [1:0][3:0]        divExp;
        logic [31:0]            sampleRate;
        logic [31:0]            refRate;
        logic signed [31:0]     pointOffset;
        logic signed [9:0]      fineSkew;
    } dccs_cfg_type;

    typedef struct packed {
        logic                   external;
        logic [3:0]             divExp;
    } dccs_chclk_type;

    typedef struct packed {
        logic                   valid;
        logic signed [31:0]     pointOffset;
        logic signed [9:0]      fineSkew;
    } dccs_align_type;

endpackage : dccs_pkg

// File: hw/dccs_sat_clamp.sv
// Purpose: symmetric saturation of a signed setting to plus or minus a limit
// Assumes: limit is not negative
// Notes:   purely combinational
`timescale 1ns/100ps
module dccs_sat_clamp #(
    parameter int W = 32
) (
    input  wire logic signed [W-1:0] value,   // setting as written
    input  wire logic signed [W-1:0] limit,   // magnitude bound
    output logic signed [W-1:0]      clamped  // setting within bound
);
    always_comb
    begin
        if (value > limit)
            clamped = limit;
        else if (value < -limit)
            clamped = -limit;
        else
            clamped = value;
    end
endmodule : dccs_sat_clamp

// File: hw/dccs_pow2_divider.sv
// Purpose: divide an external sample tick stream by 2 to the power divExp
// Assumes: sampleTick is a one-cycle pulse synchronous to ref_clk
// Notes:   one cycle of latency; restart realigns the phase after a commit
`timescale 1ns/100ps
module dccs_pow2_divider (
    input  wire logic       ref_clk,    // system clock
    input  wire logic       rst,        // synchronous reset, high
    input  wire logic       sampleTick, // undivided external tick
    input  wire logic [3:0] divExp,     // exponent 0..8
    input  wire logic       restart,    // clear the phase counter
    output logic            divTick     // divided tick, registered
);
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic       divTick_ff;
    logic       nxt_divTick;
    logic [7:0] terminal;

    assign terminal = 8'((9'h001 << divExp) - 9'h001);
    assign divTick  = divTick_ff;

    always_comb
    begin
        nxt_count   = count_ff;
        nxt_divTick = 1'b0;
        if (restart)
            nxt_count = 8'h00;
        else if (sampleTick)
        begin
            if (count_ff >= terminal)
            begin
                nxt_count   = 8'h00;
                nxt_divTick = 1'b1;
            end
            else
                nxt_count = count_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            count_ff   <= 8'h00;
            divTick_ff <= 1'b0;
        end
        else
        begin
            count_ff   <= nxt_count;
            divTick_ff <= nxt_divTick;
        end
    end
endmodule : dccs_pow2_divider

// File: hw/dccs_clock_control.sv
// Purpose: sample clock and reference selection, external divider and channel alignment
// Assumes: APB slave, zero wait states beyond the access phase; ticks synchronous
// Notes:   settings are staged by writes and take effect together on commit
//
// What this block does
// - each channel configured independently of other
// - common feed drives both from one clock
// - synchronized channels share rate, keep own settings
// - common feed blocks channel 2 clock changes
// - offset and skew locked unless common
// - point offset delays channel 2, clamped
// - fine skew within 3 ns, 10 ps
// - external input routable to either or both
// - per-channel internal or external source select
// - external rate used only when selected
// - external clock divided by 1 to 256
// - one reference feeds both generators
// - reference select; external rate when selected
// - internal reference is 100 MHz
// - missing external clock gives no indication
`timescale 1ns/100ps
`include "dccs_consts.svh"
module dccs_clock_control (
    input  wire logic                        ref_clk,          // 125 MHz clock
    input  wire logic                        rst,              // synchronous reset, high
    input  wire logic                        psel,             // APB select
    input  wire logic                        penable,          // APB access phase
    input  wire logic                        pwrite,           // APB direction
    input  wire logic [`DCCS_ADDR_W-1:0]     paddr,            // APB byte address
    input  wire logic [31:0]                 pwdata,           // APB write data
    output logic                             pready,           // APB ready
    output logic [31:0]                      prdata,           // APB read data
    output logic                             pslverr,          // APB error, unmapped
    input  wire logic [1:0]                  intSampleTick,    // internal generator ticks
    input  wire logic                        externalTick,     // external sample clock tick
    input  wire logic [31:0]                 waveLength,       // output waveform length
    output dccs_pkg::dccs_chclk_type [1:0]   chClk,            // active per-channel clock
    output logic [1:0]                       chSampleTick,     // per-channel sample tick
    output logic                             sampleRateActive, // loops use external rate
    output logic [31:0]                      loopSampleRate,   // external_sample_rate_value
    output logic [1:0]                       refExternalSel,   // reference select per gen
    output logic [31:0]                      loopRefRate,      // reference rate in kHz
    output dccs_pkg::dccs_align_type         align             // channel 2 alignment
);
    import dccs_pkg::*;

    dccs_cfg_type stg_ff;
    dccs_cfg_type nxt_stg;
    dccs_cfg_type act_ff;
    dccs_cfg_type nxt_act;
    logic [31:0]  prdata_ff;
    logic [31:0]  nxt_prdata;
    logic         commit_ff;
    logic         nxt_commit;

    logic         setup;
    logic         access;
    logic         wrEn;
    logic         mapped;
    logic [31:0]  statusWord;
    logic [3:0]   wrDiv1;
    logic [3:0]   wrDiv2;
    logic         newCommon;
    logic signed [31:0] clampOffset;
    logic signed [9:0]  clampSkew;
    logic signed [31:0] offsetLimit;
    logic [1:0]   divTick;
    logic [1:0]   chSrcExt;

    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wrEn   = access & pwrite;

    // misaligned or out-of-range addresses fall to the default and raise pslverr
    always_comb
    begin
        case (paddr)
            `DCCS_OFS_CTRL, `DCCS_OFS_DIV, `DCCS_OFS_SRATE, `DCCS_OFS_RRATE,
            `DCCS_OFS_XOFS, `DCCS_OFS_XSKEW, `DCCS_OFS_COMMIT, `DCCS_OFS_STATUS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    // read data is latched in the setup phase, so the access phase can be ready at once
    assign pready  = access;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_ff;

    // exponents above eight saturate at write, so readback shows what will be used
    function automatic logic [3:0] limit_exp(input logic [3:0] e);
        limit_exp = (e > `DCCS_DIV_EXP_MAX) ? `DCCS_DIV_EXP_MAX : e;
    endfunction : limit_exp

    assign wrDiv1    = limit_exp(pwdata[`DCCS_DIV_CH1_LSB +: 4]);
    assign wrDiv2    = limit_exp(pwdata[`DCCS_DIV_CH2_LSB +: 4]);
    assign newCommon = pwdata[`DCCS_CTRL_COMMON];

    assign offsetLimit = $signed({1'b0, waveLength[30:0]});

    dccs_sat_clamp #(
        .W       (32)
    ) u_offset_clamp (
        .value   (stg_ff.pointOffset),
        .limit   (offsetLimit),
        .clamped (clampOffset)
    );

    dccs_sat_clamp #(
        .W       (10)
    ) u_skew_clamp (
        .value   (stg_ff.fineSkew),
        .limit   (10'(`DCCS_SKEW_LIMIT)),
        .clamped (clampSkew)
    );

    // status shows settings only: no bit reports a missing external clock
    always_comb
    begin
        statusWord                              = `DCCS_RST_WORD;
        statusWord[`DCCS_CTRL_COMMON]           = act_ff.common;
        statusWord[`DCCS_CTRL_CH1_SRC]          = act_ff.chExternal[0];
        statusWord[`DCCS_CTRL_CH2_SRC]          = act_ff.chExternal[1];
        statusWord[`DCCS_CTRL_REF_SRC]          = act_ff.refExternal;
        statusWord[`DCCS_ST_SRATE_ACT]          = sampleRateActive;
        statusWord[`DCCS_ST_ALIGN_ACT]          = align.valid;
        statusWord[`DCCS_ST_DIV1_LSB +: 4]      = chClk[0].divExp;
        statusWord[`DCCS_ST_DIV2_LSB +: 4]      = chClk[1].divExp;
    end

    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (setup & ~pwrite)
        begin
            case (paddr)
                `DCCS_OFS_CTRL:
                begin
                    nxt_prdata                     = `DCCS_RST_WORD;
                    nxt_prdata[`DCCS_CTRL_COMMON]  = stg_ff.common;
                    nxt_prdata[`DCCS_CTRL_CH1_SRC] = stg_ff.chExternal[0];
                    nxt_prdata[`DCCS_CTRL_CH2_SRC] = stg_ff.chExternal[1];
                    nxt_prdata[`DCCS_CTRL_REF_SRC] = stg_ff.refExternal;
                end
                `DCCS_OFS_DIV:
                begin
                    nxt_prdata                         = `DCCS_RST_WORD;
                    nxt_prdata[`DCCS_DIV_CH1_LSB +: 4] = stg_ff.divExp[0];
                    nxt_prdata[`DCCS_DIV_CH2_LSB +: 4] = stg_ff.divExp[1];
                end
                `DCCS_OFS_SRATE:  nxt_prdata = stg_ff.sampleRate;
                `DCCS_OFS_RRATE:  nxt_prdata = stg_ff.refRate;
                `DCCS_OFS_XOFS:   nxt_prdata = stg_ff.pointOffset;
                `DCCS_OFS_XSKEW:  nxt_prdata = 32'(stg_ff.fineSkew);
                `DCCS_OFS_STATUS: nxt_prdata = statusWord;
                default:          nxt_prdata = `DCCS_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            prdata_ff <= `DCCS_RST_WORD;
        else
            prdata_ff <= nxt_prdata;
    end

    // staging: writes land here and touch no clock until a commit
    always_comb
    begin
        nxt_stg    = stg_ff;
        nxt_commit = 1'b0;

        if (wrEn)
        begin
            case (paddr)
                `DCCS_OFS_CTRL:
                begin
                    nxt_stg.common        = newCommon;
                    nxt_stg.chExternal[0] = pwdata[`DCCS_CTRL_CH1_SRC];
                    // channel 2 clock is frozen while the feed is, or becomes, common
                    if (!stg_ff.common && !newCommon)
                        nxt_stg.chExternal[1] = pwdata[`DCCS_CTRL_CH2_SRC];
                    nxt_stg.refExternal   = pwdata[`DCCS_CTRL_REF_SRC];
                end
                `DCCS_OFS_DIV:
                begin
                    // in common feed channel 2 follows channel 1, so its field stays put
                    nxt_stg.divExp[0] = wrDiv1;
                    if (!stg_ff.common)
                        nxt_stg.divExp[1] = wrDiv2;
                end
                `DCCS_OFS_SRATE: nxt_stg.sampleRate = pwdata;
                `DCCS_OFS_RRATE: nxt_stg.refRate    = pwdata;
                `DCCS_OFS_XOFS:
                begin
                    if (act_ff.common)
                        nxt_stg.pointOffset = $signed(pwdata);
                end
                `DCCS_OFS_XSKEW:
                begin
                    if (act_ff.common)
                        nxt_stg.fineSkew = $signed(pwdata[9:0]);
                end
                `DCCS_OFS_COMMIT: nxt_commit = pwdata[`DCCS_COMMIT_BIT];
                default:          nxt_commit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stg_ff    <= '0;
            commit_ff <= 1'b0;
        end
        else
        begin
            stg_ff    <= nxt_stg;
            commit_ff <= nxt_commit;
        end
    end

    // the whole staged set moves at once, so the clocks never see a half update
    always_comb
    begin
        nxt_act = act_ff;
        if (commit_ff)
        begin
            nxt_act             = stg_ff;
            nxt_act.pointOffset = clampOffset;
            nxt_act.fineSkew    = clampSkew;
            if (!stg_ff.common)
            begin
                nxt_act.pointOffset = 32'sh00000000;
                nxt_act.fineSkew    = 10'sh000;
            end
        end
    end

    // reset leaves both channels on their own internal clocks, undivided
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            act_ff <= '0;
        else
            act_ff <= nxt_act;
    end

    // channel 2 mirrors channel 1 in common feed: one source, one rate for both
    assign chClk[0].external = act_ff.chExternal[0];
    assign chClk[0].divExp   = act_ff.divExp[0];
    assign chClk[1].external = act_ff.common ? act_ff.chExternal[0]
                                             : act_ff.chExternal[1];
    assign chClk[1].divExp   = act_ff.common ? act_ff.divExp[0]
                                             : act_ff.divExp[1];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            assign chSrcExt[ch] = chClk[ch].external;

            // the single external tick fans out to each divider that wants it
            dccs_pow2_divider u_div (
                .ref_clk    (ref_clk),
                .rst        (rst),
                .sampleTick (externalTick & chSrcExt[ch]),
                .divExp     (chClk[ch].divExp),
                .restart    (commit_ff),
                .divTick    (divTick[ch])
            );
        end
    endgenerate

    // common feed takes channel 1's tick for both, so both start on the same edge
    always_comb
    begin
        chSampleTick[0] = chSrcExt[0] ? divTick[0] : intSampleTick[0];
        if (act_ff.common)
            chSampleTick[1] = chSampleTick[0];
        else
            chSampleTick[1] = chSrcExt[1] ? divTick[1] : intSampleTick[1];
    end

    assign sampleRateActive = |chSrcExt;
    assign loopSampleRate   = sampleRateActive ? act_ff.sampleRate : `DCCS_RST_WORD;

    // one select for both generators; an absent external clock is not flagged
    assign refExternalSel   = {2{act_ff.refExternal}};
    assign loopRefRate      = act_ff.refExternal ? act_ff.refRate
                                                 : 32'(`DCCS_INT_REF_KHZ);
    // alignment only means something while both channels share one clock
    assign align.valid       = act_ff.common;
    assign align.pointOffset = act_ff.pointOffset;
    assign align.fineSkew    = act_ff.fineSkew;

endmodule : dccs_clock_control

// File: testbench/dccs_clock_control_properties.sv
// Purpose: port assertions for the clock control
// Assumes: a write of bit0 to the commit word starts a commit
// Notes:   bound to every dccs_clock_control instance
`timescale 1ns/100ps
`include "dccs_consts.svh"
module dccs_clock_control_checker (
    input wire logic                          ref_clk,          // clock
    input wire logic                          rst,              // reset
    input wire logic                          psel,             // select
    input wire logic                          penable,          // access
    input wire logic                          pwrite,           // direction
    input wire logic [`DCCS_ADDR_W-1:0]       paddr,            // address
    input wire logic [31:0]                   pwdata,           // write data
    input wire logic [1:0]                    intSampleTick,    // internal ticks
    input wire dccs_pkg::dccs_chclk_type [1:0] chClk,           // channel clocks
    input wire logic [1:0]                    chSampleTick,     // channel ticks
    input wire logic                          sampleRateActive, // ext rate used
    input wire logic [31:0]                   loopSampleRate,   // ext rate
    input wire logic [1:0]                    refExternalSel,   // ref select
    input wire logic [31:0]                   loopRefRate,      // ref rate
    input wire dccs_pkg::dccs_align_type      align             // alignment
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // three edges of history cover the staged-to-active hop and the aligned copy;
    // a reset counts as a commit, since it rewrites the active set as well
    logic [2:0] cmtHist_ff;
    logic [2:0] nxt_cmtHist;
    always_comb
        nxt_cmtHist = {cmtHist_ff[1:0],
                       rst || (psel && penable && pwrite &&
                               paddr == `DCCS_OFS_COMMIT && pwdata[0])};
    always_ff @(posedge ref_clk)
        cmtHist_ff <= nxt_cmtHist;

    shared_ref_sel_a: assert property (refExternalSel[0] == refExternalSel[1])
        else $error("reference select differs between generators");
    int_ref_rate_a: assert property (!refExternalSel[0] |-> loopRefRate == `DCCS_INT_REF_KHZ)
        else $error("internal reference rate wrong");
    ext_rate_on_a: assert property (sampleRateActive == (chClk[0].external || chClk[1].external))
        else $error("external rate activity disagrees with sources");
    ext_rate_idle_a: assert property (!sampleRateActive |-> loopSampleRate == 32'h0)
        else $error("external rate seen while unused");
    div_range_a: assert property (chClk[0].divExp <= 4'h8 && chClk[1].divExp <= 4'h8)
        else $error("divider exponent above eight");
    align_gate_a: assert property (!align.valid |-> align.pointOffset == 0 && align.fineSkew == 0)
        else $error("alignment applied without common feed");
    skew_range_a: assert property (align.fineSkew <= 10'sh12c && align.fineSkew >= -10'sh12c)
        else $error("fine skew beyond limit");
    int_tick_a: assert property (!chClk[0].external |-> chSampleTick[0] == intSampleTick[0])
        else $error("channel one tick not internal");
    commit_only_a: assert property (!$stable({chClk, align}) |-> |cmtHist_ff)
        else $error("active setting changed without commit");
    common_mirror_a: assert property (align.valid |-> chClk[1] == chClk[0])
        else $error("channel two clock differs in common feed");
endmodule : dccs_clock_control_checker

bind dccs_clock_control dccs_clock_control_checker i_dccs_clock_control_checker (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .intSampleTick, .chClk,
    .chSampleTick, .sampleRateActive, .loopSampleRate, .refExternalSel, .loopRefRate, .align
);

// File: testbench/dccs_clock_control_test.sv
// Purpose: directed bench for the clock control
// Assumes: zero wait APB slave, commit visible within three edges
// Notes:   ticks are driven by the bench itself
`timescale 1ns/100ps
`include "dccs_consts.svh"
module dccs_clock_control_test;
    import dccs_pkg::*;
    logic                 ref_clk;
    logic                 rst;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic                 externalTick;
    logic                 pready;
    logic                 pslverr;
    logic                 sampleRateActive;
    logic                 rdErr;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic [31:0]          waveLength;
    logic [31:0]          loopSampleRate;
    logic [31:0]          loopRefRate;
    logic [31:0]          rdData;
    logic [1:0]           intSampleTick = 2'h0;
    logic [1:0]           chSampleTick;
    logic [1:0]           refExternalSel;
    dccs_chclk_type [1:0] chClk;
    dccs_align_type       align;
    int                   error_cnt = 0;
    int                   n_compared = 0;

    dccs_clock_control i_dccs_clock_control (
        .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .intSampleTick, .externalTick, .waveLength, .chClk, .chSampleTick,
        .sampleRateActive, .loopSampleRate, .refExternalSel, .loopRefRate, .align
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // a counting pattern keeps both internal tick lines busy and distinct
    always @(posedge ref_clk)
        intSampleTick <= intSampleTick + 2'h1;

    task give_verdict;
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16 && pready !== 1'b1; i++)
            @(posedge ref_clk);
        if (i == 16)
        begin
            error_cnt++;
            give_verdict;
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task commit;
        apb(1'b1, `DCCS_OFS_COMMIT, 32'h1);
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : commit

    task t_reset;
        check("ref rate", loopRefRate, 32'h186a0);
        apb(1'b0, `DCCS_OFS_STATUS, 32'h0);
        check("status", rdData, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped", {rdErr, rdData}, {1'b1, 32'h0});
        apb(1'b0, 8'h02, 32'h0);
        check("misaligned", rdErr, 1'b1);
        apb(1'b1, `DCCS_OFS_XOFS, 32'h5);
        apb(1'b0, `DCCS_OFS_XOFS, 32'h0);
        check("offset locked", rdData, 32'h0);
    endtask : t_reset

    task t_ext_div;
        int n;
        apb(1'b1, `DCCS_OFS_CTRL, 32'h2);
        apb(1'b1, `DCCS_OFS_DIV, 32'h92);
        apb(1'b1, `DCCS_OFS_SRATE, 32'h003d0900);
        apb(1'b0, `DCCS_OFS_DIV, 32'h0);
        check("div clamp", rdData, 32'h82);
        check("staged only", chClk[0].external, 1'b0);
        commit;
        check("ch1 ext", {chClk[0], sampleRateActive}, {1'b1, 4'h2, 1'b1});
        check("ext rate", loopSampleRate, 32'h003d0900);
        n = 0;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            externalTick <= (i < 32) && i[0];
            n += chSampleTick[0];
            check("ch2 own", chSampleTick[1], intSampleTick[1]);
        end
        check("div ticks", n, 4);
    endtask : t_ext_div

    task t_common;
        waveLength <= 32'h32;
        apb(1'b1, `DCCS_OFS_CTRL, 32'h5);
        apb(1'b0, `DCCS_OFS_CTRL, 32'h0);
        check("ch2 blocked", rdData, 32'h1);
        apb(1'b1, `DCCS_OFS_DIV, 32'h52);
        apb(1'b0, `DCCS_OFS_DIV, 32'h0);
        check("div2 blocked", rdData, 32'h82);
        commit;
        check("common clk", chClk[1], {1'b0, 4'h2});
        check("same tick", chSampleTick[1], chSampleTick[0]);
        apb(1'b1, `DCCS_OFS_XOFS, 32'h64);
        apb(1'b1, `DCCS_OFS_XSKEW, 32'hfffffe70);
        commit;
        check("align", align, {1'b1, 32'h32, 10'h2d4});
    endtask : t_common

    task t_both_ext;
        apb(1'b1, `DCCS_OFS_CTRL, 32'h8);
        apb(1'b1, `DCCS_OFS_CTRL, 32'he);
        apb(1'b1, `DCCS_OFS_RRATE, 32'h2710);
        commit;
        check("align off", align, 43'h0);
        check("ref sel", refExternalSel, 2'h3);
        check("ref rate", loopRefRate, 32'h2710);
        check("both ext", {chClk[1].external, chClk[0].external}, 2'h3);
        apb(1'b0, `DCCS_OFS_STATUS, 32'h0);
        check("status", rdData, 32'h821e);
    endtask : t_both_ext

    // reset in mid-run must drop every active setting back to internal clocks
    task t_mid_reset;
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check("reset ref", {refExternalSel, loopRefRate}, {2'h0, 32'h186a0});
        check("reset clk", {chClk, sampleRateActive, align}, 64'h0);
        apb(1'b0, `DCCS_OFS_DIV, 32'h0);
        check("reset div", rdData, 32'h0);
    endtask : t_mid_reset

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        externalTick = 1'b0;
        waveLength = 32'h0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_ext_div;
        t_common;
        t_both_ext;
        t_mid_reset;
        give_verdict;
    end
endmodule : dccs_clock_control_test
